/* File: acr_regs.svh */
// Constants for the converter conversion control and result readout block
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ==========================================================
// Widths and positions
`define ACR_DATA_W       16
`define ACR_FIFO_DEPTH   4
`define ACR_MSB_IDX      4'hF
`define ACR_LAST_BIT     4'hF
`define ACR_NBITS        5'h10
`define ACR_BYTE_W       8

// ==========================================================
// Synchronised pin vector layout
`define ACR_NSYNC        11
`define ACR_PIN_START    0
`define ACR_PIN_PD       1
`define ACR_PIN_RESET    2
`define ACR_PIN_CS       3
`define ACR_PIN_RD       4
`define ACR_PIN_CODING   5
`define ACR_PIN_SERIAL   6
`define ACR_PIN_SWAP     7
`define ACR_PIN_EXT      8
`define ACR_PIN_RDC      9
`define ACR_PIN_SCLK     10
// Idle levels: start, chip select and read enable high, the rest low
`define ACR_SYNC_RST     11'h019

// ==========================================================
// Timing
`define ACR_CLK_PERIOD_NS  8
`define ACR_BIT_TIME_NS    40
`define ACR_INIT_TIME_NS   200
`define ACR_SCLK_HALF_NS   16
`define ACR_BIT_BASE_CYC   4'((`ACR_BIT_TIME_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
`define ACR_INIT_CYC       8'((`ACR_INIT_TIME_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
`define ACR_SCLK_HALF_CYC  4'((`ACR_SCLK_HALF_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)

`endif

/* File: acr_pkg.sv */
// Types shared by the converter readout block
package acr_pkg;

  // ==========================================================
  // Main sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CONV  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_HOLD  = 3'h3,
    ST_INIT  = 3'h4
  } acr_state_e;

endpackage : acr_pkg

/* File: acr_fifo.sv */
// Small result FIFO with valid and ready on both sides
`timescale 1ns/100ps
module acr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push;
  wire              pop;

  // Pointers carry one extra bit so full and empty are told apart
  assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end

endmodule : acr_fifo

/* File: acr_readout.sv */
// Conversion control and result readout of a 16-bit successive-approximation converter
// What this block does
// R1: A start pin falling edge begins a conversion, regardless of select and read.
// R2: A running conversion finishes; start edges and power-down cannot restart or abort it.
// R3: Host returns start high before the maximum low time, or after conversion ends.
// R4: Interface outputs float unless chip select and read enable are both low.
// R5: Output coding select picks two's complement or straight binary results.
// R6: Reset pin rising edge aborts conversion and floats the data bus.
// R7: Reset pin falling edge clears the bus and pulses busy for initialisation.
// R8: Serial/parallel select low uses the parallel bus, high the serial port.
// R9: With selects tied low the bus always shows the latest result, except in reset.
// R10: Host may read a result after its conversion or during the next one.
// R11: Host finishes reads during a conversion within its first half.
// R12: Byte order select swaps the result bytes on the data bus.
// R13: Serial mode shifts 16 bits out, most significant first, one per clock.
// R14: Each serial bit stays valid across both edges of its clock pulse.
// R15: Internal clock mode drives serial clock and frame valid, both optionally inverted.
// R16: Master serial sends after conversion or during the next, per read-during select.
// R17: Master read-during clock follows the bit steps, longer for low bits.
// R18: Master read-after keeps busy high until all 16 bits are out.
// R19: External clock counts only with select low; shifting needs select and read low.
// R20: External clock may be continuous or idle high or low between bursts.
// R21: Host toggles an external clock only while busy is low.
// R22: Busy is high during conversion and falls when the result is ready.
// R23: Host discards the first 128 results after power-up unless reset is pulsed.
// R24: Busy rises one cycle after an accepted start; starts are ignored while busy.
`timescale 1ns/100ps
`include "acr_regs.svh"
module acr_readout import acr_pkg::*; (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   conversion_start_n,
  input  wire logic                   power_down_input,
  input  wire logic                   reset_pin,
  input  wire logic                   chip_select_n,
  input  wire logic                   read_enable_n,
  input  wire logic                   output_coding_select,
  input  wire logic                   serial_parallel_select,
  input  wire logic                   byte_order_select,
  input  wire logic                   clock_source_select,
  input  wire logic                   read_during_convert_select,
  input  wire logic                   invert_serial_select,
  input  wire logic                   sclk_in,
  input  wire logic [`ACR_DATA_W-1:0] sar_data,
  output logic      [`ACR_DATA_W-1:0] data_out,
  output logic                        data_oe,
  output logic                        busy,
  output logic                        serial_data_output,
  output logic                        serial_data_oe,
  output logic                        sclk_out,
  output logic                        sclk_oe,
  output logic                        frame_valid
);

  // ==========================================================
  // Pin synchronisers
  wire  [`ACR_NSYNC-1:0] pin_raw;
  logic [`ACR_NSYNC-1:0] sync1_reg;
  logic [`ACR_NSYNC-1:0] sync2_reg;
  localparam logic [`ACR_NSYNC-1:0] SYNC_RST = `ACR_SYNC_RST;
  assign pin_raw = {sclk_in, read_during_convert_select, clock_source_select, byte_order_select,
                    serial_parallel_select, output_coding_select, read_enable_n, chip_select_n,
                    reset_pin, power_down_input, conversion_start_n};
  genvar gi;
  generate
    for (gi = 0; gi < `ACR_NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sync1_reg[gi] <= SYNC_RST[gi];
          sync2_reg[gi] <= SYNC_RST[gi];
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  wire start_s  = sync2_reg[`ACR_PIN_START];
  wire pd_s     = sync2_reg[`ACR_PIN_PD];
  wire rpin_s   = sync2_reg[`ACR_PIN_RESET];
  wire cs_s     = sync2_reg[`ACR_PIN_CS];
  wire rd_s     = sync2_reg[`ACR_PIN_RD];
  wire coding_s = sync2_reg[`ACR_PIN_CODING];
  wire serial_s = sync2_reg[`ACR_PIN_SERIAL];
  wire swap_s   = sync2_reg[`ACR_PIN_SWAP];
  wire ext_s    = sync2_reg[`ACR_PIN_EXT];
  wire rdc_s    = sync2_reg[`ACR_PIN_RDC];
  wire sclk_s   = sync2_reg[`ACR_PIN_SCLK];
  // ==========================================================
  // Edge detection and state
  logic                   prev_start_reg;
  logic                   prev_rpin_reg;
  logic                   prev_sclk_reg;
  acr_state_e             state_reg, state_next;
  logic [3:0]             step_idx_reg, step_idx_next;
  logic [3:0]             step_cnt_reg, step_cnt_next;
  logic [4:0]             bit_cnt_reg, bit_cnt_next;
  logic [3:0]             half_cnt_reg, half_cnt_next;
  logic                   sclk_ph_reg, sclk_ph_next;
  logic [7:0]             init_cnt_reg, init_cnt_next;
  logic [4:0]             slv_bit_reg, slv_bit_next;
  logic                   slv_ph_reg, slv_ph_next;
  logic [`ACR_DATA_W-1:0] latest_reg;
  wire start_fall = prev_start_reg & ~start_s;
  wire rp_rise    = ~prev_rpin_reg & rpin_s;
  wire rp_fall    = prev_rpin_reg & ~rpin_s;
  wire sclk_edge  = prev_sclk_reg ^ sclk_s;
  // Mode decode
  wire selected     = ~cs_s & ~rd_s;
  wire master_ser   = serial_s & ~ext_s;
  wire master_rdc   = master_ser & rdc_s;
  wire slave_ser    = serial_s & ext_s;
  wire slave_active = slave_ser & selected;
  // FIFO hookup; a full FIFO refuses new starts, which is how the drain side pushes back
  wire                   fifo_in_ready;
  wire                   fifo_out_valid;
  wire [`ACR_DATA_W-1:0] fifo_out_data;
  wire [3:0]             step_len  = `ACR_BIT_BASE_CYC + {2'h0, step_idx_reg[3:2]};     // [R17]
  wire                   step_end  = (step_cnt_reg == step_len - 4'h1);
  wire                   conv_done = (state_reg == ST_CONV) && step_end && (step_idx_reg == `ACR_LAST_BIT);
  wire start_go = start_fall && (state_reg == ST_IDLE) && !pd_s && fifo_in_ready;       // [R1] [R24]
  wire [`ACR_DATA_W-1:0] coded = {sar_data[`ACR_DATA_W-1] ^ ~coding_s, sar_data[`ACR_DATA_W-2:0]}; // [R5]
  wire drain_ok = !slave_active && !((state_reg == ST_CONV) && master_rdc);
  wire pop      = fifo_out_valid && drain_ok;
  acr_fifo #(
    .WIDTH (`ACR_DATA_W),
    .DEPTH (`ACR_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (conv_done),
    .in_ready  (fifo_in_ready),
    .in_data   (coded),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ok),
    .out_data  (fifo_out_data)
  );
  // ==========================================================
  // Sequencer
  always_comb begin
    state_next    = state_reg;
    step_idx_next = step_idx_reg;
    step_cnt_next = step_cnt_reg;
    bit_cnt_next  = bit_cnt_reg;
    half_cnt_next = half_cnt_reg;
    sclk_ph_next  = sclk_ph_reg;
    init_cnt_next = init_cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_go) begin
          state_next    = ST_CONV;
          step_idx_next = 4'h0;
          step_cnt_next = 4'h0;
        end
      end
      ST_CONV: begin
        // Only a reset pin rising edge leaves this state early
        if (!step_end) begin
          step_cnt_next = step_cnt_reg + 4'h1;                                          // [R2]
        end else if (step_idx_reg != `ACR_LAST_BIT) begin
          step_idx_next = step_idx_reg + 4'h1;
          step_cnt_next = 4'h0;
        end else begin
          state_next    = (master_ser && !rdc_s) ? ST_SHIFT : ST_IDLE;                  // [R16] [R22]
          bit_cnt_next  = 5'h00;
          half_cnt_next = 4'h0;
          sclk_ph_next  = 1'b0;
        end
      end
      ST_SHIFT: begin
        // Wait until the new result has reached the output register
        if (!fifo_out_valid) begin
          if (half_cnt_reg == `ACR_SCLK_HALF_CYC - 4'h1) begin
            half_cnt_next = 4'h0;
            sclk_ph_next  = ~sclk_ph_reg;
            if (sclk_ph_reg) begin
              bit_cnt_next = bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == `ACR_NBITS - 5'h01) begin
                state_next = ST_IDLE;                                                   // [R18]
              end
            end
          end else begin
            half_cnt_next = half_cnt_reg + 4'h1;
          end
        end
      end
      ST_HOLD: begin
        if (rp_fall) begin
          state_next    = ST_INIT;                                                      // [R7]
          init_cnt_next = 8'h00;
        end
      end
      ST_INIT: begin
        if (init_cnt_reg == `ACR_INIT_CYC - 8'h01) begin
          state_next = ST_IDLE;
        end else begin
          init_cnt_next = init_cnt_reg + 8'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (rp_rise) begin
      state_next = ST_HOLD;                                                             // [R6]
    end
  end
  // External clock: two edges make one pulse, so either idle level works
  always_comb begin
    slv_bit_next = slv_bit_reg;
    slv_ph_next  = slv_ph_reg;
    if (!slave_active) begin
      slv_bit_next = 5'h00;                                                             // [R19]
      slv_ph_next  = 1'b0;
    end else if (sclk_edge && (slv_bit_reg != `ACR_NBITS)) begin
      slv_ph_next = ~slv_ph_reg;                                                        // [R20]
      if (slv_ph_reg) begin
        slv_bit_next = slv_bit_reg + 5'h01;
      end
    end
  end
  // ==========================================================
  // Output selection
  wire [3:0] ser_idx = slave_ser ? slv_bit_reg[3:0] : (rdc_s ? step_idx_reg : bit_cnt_reg[3:0]);
  wire ser_last  = slave_ser && (slv_bit_reg == `ACR_NBITS);
  wire sdo_next  = ser_last ? 1'b0 : latest_reg[`ACR_MSB_IDX - ser_idx];                // [R13] [R14]
  wire rdc_clk   = (state_reg == ST_CONV) && (step_cnt_reg < {1'b0, step_len[3:1]});    // [R17]
  wire after_clk = (state_reg == ST_SHIFT) && sclk_ph_reg;
  wire sclk_next = (rdc_s ? rdc_clk : after_clk) ^ invert_serial_select;                // [R15]
  wire fv_raw    = rdc_s ? (state_reg == ST_CONV) : ((state_reg == ST_SHIFT) && !fifo_out_valid);
  wire fv_next   = fv_raw ^ invert_serial_select;                                       // [R15]
  wire in_hold   = (state_next == ST_HOLD);
  wire [`ACR_DATA_W-1:0] bus_next = swap_s ? {latest_reg[`ACR_BYTE_W-1:0], latest_reg[`ACR_DATA_W-1:`ACR_BYTE_W]}
                                           : latest_reg;                                // [R12]
  wire data_oe_next = !serial_s && selected && !in_hold;                                // [R4] [R8] [R9] [R10]
  wire sdo_oe_next  = serial_s && selected && !in_hold;                                 // [R4] [R19]
  wire busy_next    = (state_next == ST_CONV) || (state_next == ST_SHIFT) || (state_next == ST_INIT); // [R22]
  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_start_reg <= 1'b1;
      prev_rpin_reg  <= 1'b0;
      prev_sclk_reg  <= 1'b0;
      state_reg      <= ST_IDLE;
      step_idx_reg   <= 4'h0;
      step_cnt_reg   <= 4'h0;
      bit_cnt_reg    <= 5'h00;
      half_cnt_reg   <= 4'h0;
      sclk_ph_reg    <= 1'b0;
      init_cnt_reg   <= 8'h00;
      slv_bit_reg    <= 5'h00;
      slv_ph_reg     <= 1'b0;
    end else begin
      prev_start_reg <= start_s;
      prev_rpin_reg  <= rpin_s;
      prev_sclk_reg  <= sclk_s;
      state_reg      <= state_next;
      step_idx_reg   <= step_idx_next;
      step_cnt_reg   <= step_cnt_next;
      bit_cnt_reg    <= bit_cnt_next;
      half_cnt_reg   <= half_cnt_next;
      sclk_ph_reg    <= sclk_ph_next;
      init_cnt_reg   <= init_cnt_next;
      slv_bit_reg    <= slv_bit_next;
      slv_ph_reg     <= slv_ph_next;
    end
  end

  // Latest result; the clear on reset release beats a pop in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst || rp_fall) begin
      latest_reg <= '0;                                                                 // [R7]
    end else if (pop) begin
      latest_reg <= fifo_out_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_out           <= '0;
      data_oe            <= 1'b0;
      busy               <= 1'b0;
      serial_data_output <= 1'b0;
      serial_data_oe     <= 1'b0;
      sclk_out           <= 1'b0;
      sclk_oe            <= 1'b0;
      frame_valid        <= 1'b0;
    end else begin
      data_out           <= rp_fall ? '0 : bus_next;
      data_oe            <= data_oe_next;
      busy               <= busy_next;                                                  // [R24]
      serial_data_output <= sdo_next;
      serial_data_oe     <= sdo_oe_next;
      sclk_out           <= master_ser ? sclk_next : 1'b0;
      sclk_oe            <= master_ser && selected && !in_hold;                         // [R15] [R4]
      frame_valid        <= master_ser ? fv_next : 1'b0;
    end
  end

  // ==========================================================
  // Checks
  start_busy_a: assert property (@(posedge core_clk) disable iff (rst) // [R24]
    start_go |=> busy ##1 (state_reg == ST_CONV))
    else $error("accepted start did not raise busy");
  conv_runs_a: assert property (@(posedge core_clk) disable iff (rst) // [R2]
    (state_reg == ST_CONV) && !conv_done && !rp_rise |=> (state_reg == ST_CONV))
    else $error("conversion left early");
  bus_float_a: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    (cs_s || rd_s) |=> !data_oe && !serial_data_oe && !sclk_oe)
    else $error("outputs driven while deselected");
  coding_sel_a: assert property (@(posedge core_clk) disable iff (rst) // [R5]
    conv_done |-> ((coded ^ sar_data) == {!coding_s, 15'h0000}))
    else $error("wrong output coding");
  reset_abort_a: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    rp_rise |=> (state_reg == ST_HOLD) && !busy ##1 !data_oe)
    else $error("reset edge did not abort");
  reset_init_a: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    (state_reg == ST_HOLD) && rp_fall && !rp_rise |=> busy && (latest_reg == '0) && (data_out == '0))
    else $error("reset release did not start init");
  byte_swap_a: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    $past(swap_s) && !$past(rp_fall) |-> data_out == {$past(latest_reg[7:0]), $past(latest_reg[15:8])})
    else $error("byte order wrong");
  par_ser_a: assert property (@(posedge core_clk) disable iff (rst) // [R8]
    serial_s |=> !data_oe)
    else $error("parallel bus driven in serial mode");
  busy_tail_a: assert property (@(posedge core_clk) disable iff (rst) // [R18]
    (state_reg == ST_SHIFT) && (state_next == ST_IDLE) |-> (bit_cnt_reg == `ACR_NBITS - 5'h01) && sclk_ph_reg)
    else $error("busy fell before sixteen bits");
  master_clk_a: assert property (@(posedge core_clk) disable iff (rst) // [R15]
    master_ser && selected && !in_hold && (state_reg == ST_IDLE) |=> sclk_oe
      && (sclk_out == $past(invert_serial_select)) && (frame_valid == $past(invert_serial_select)))
    else $error("internal serial clock not driven");

endmodule : acr_readout

/* File: acr_host_model.sv */
// Host-side model: external serial clock source and serial result reader
`timescale 1ns/100ps
module acr_host_model (
  input  wire logic busy,
  input  wire logic serial_data_output,
  output logic      sclk_in
);
  // ==========================================
  // Link clock, 80 ns period, still between frames
  initial sclk_in = 1'b0;

  // Idle level high or low, set while deselected
  task automatic park(input logic lvl);
    sclk_in = lvl;
    #100;
  endtask : park

  // Toggles only once busy is low, so no edge lands in a bit decision
  task automatic read_word(output logic [15:0] word);
    wait (busy === 1'b0);
    #3;
    for (int i = 15; i >= 0; i--) begin
      sclk_in = ~sclk_in;
      #40;
      word[i] = serial_data_output; // Sampled just before the closing edge
      sclk_in = ~sclk_in;
      #40;
    end
    #100;
  endtask : read_word
endmodule : acr_host_model

/* File: acr_readout_tb_top.sv */
// Self-checking testbench for the converter readout block
`timescale 1ns/100ps
module acr_readout_tb_top;
  logic        core_clk = 1'b0, rst = 1'b1, conversion_start_n = 1'b1;
  logic        power_down_input = 1'b0, reset_pin = 1'b0, chip_select_n = 1'b1, read_enable_n = 1'b1;
  logic        output_coding_select = 1'b0, serial_parallel_select = 1'b0, byte_order_select = 1'b0;
  logic        clock_source_select = 1'b0, read_during_convert_select = 1'b0, invert_serial_select = 1'b0;
  logic [15:0] sar_data = 16'h0000;
  logic [15:0] data_out, ms_word;
  logic        sclk_in, data_oe, busy, serial_data_output, serial_data_oe, sclk_out, sclk_oe, frame_valid;
  logic        sclk_q = 1'b0, fv_seen = 1'b0;
  int          err_count = 0, checked = 0, cyc = 0, ms_cnt = 0, last_rise = 0, gap_first = 0, gap_last = 0;
  logic [15:0] tbl [4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hC35A};

  acr_readout dut_u (
    .core_clk, .rst, .conversion_start_n, .power_down_input, .reset_pin, .chip_select_n,
    .read_enable_n, .output_coding_select, .serial_parallel_select, .byte_order_select,
    .clock_source_select, .read_during_convert_select, .invert_serial_select, .sclk_in,
    .sar_data, .data_out, .data_oe, .busy, .serial_data_output, .serial_data_oe, .sclk_out,
    .sclk_oe, .frame_valid
  );
  acr_host_model host_u (.busy, .serial_data_output, .sclk_in);

  // ==========================================
  // Clock, timeout and master serial monitor
  always #4 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // True clock phase is recovered so the monitor works with inversion too
  always @(posedge core_clk) begin
    sclk_q <= sclk_out ^ invert_serial_select;
    if ((sclk_out ^ invert_serial_select) && !sclk_q) begin
      ms_word <= {ms_word[14:0], serial_data_output};
      ms_cnt <= ms_cnt + 1;
      if (ms_cnt == 1) gap_first <= cyc - last_rise;
      gap_last <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (frame_valid ^ invert_serial_select) fv_seen <= 1'b1;
  end

  // ==========================================
  // Shared helpers
  function automatic logic [15:0] coded(input logic [15:0] v, input logic ob, input logic sw);
    logic [15:0] c;
    c = ob ? v : {~v[15], v[14:0]};
    return sw ? {c[7:0], c[15:8]} : c;
  endfunction : coded

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic idle(input int k);
    repeat (k) @(negedge core_clk);
  endtask : idle

  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_busy

  task automatic convert(input int lim, output int n);
    int m;
    @(negedge core_clk);
    conversion_start_n = 1'b0;
    idle(2);
    conversion_start_n = 1'b1; // Short low pulse
    wait_busy(1'b1, 6, m);
    check(16'(m < 6), 16'h0001, "busy rise");
    wait_busy(1'b0, lim, n);
  endtask : convert

  task automatic selects(input logic lvl);
    chip_select_n = lvl;
    read_enable_n = lvl;
    idle(5);
  endtask : selects

  // ==========================================
  // Scenarios
  task automatic t_parallel();
    int n;
    for (int i = 0; i < 4; i++) begin
      output_coding_select = i[0];
      byte_order_select = i[1];
      sar_data = tbl[i];
      convert(120, n);
      check(16'(n > 99 && n < 109), 16'h0001, "busy width");
      chip_select_n = 1'b0;
      idle(5);
      check({15'h0, data_oe}, 16'h0000, "bus with read high");
      selects(1'b0);
      check({15'h0, data_oe}, 16'h0001, "bus selected");
      check(data_out, coded(tbl[i], i[0], i[1]), "parallel word");
      selects(1'b1);
      check({15'h0, data_oe}, 16'h0000, "bus released");
    end
    $display("parallel test done");
  endtask : t_parallel

  task automatic t_guard();
    int n;
    selects(1'b0);
    sar_data = 16'h5A5A;
    fork
      convert(200, n);
      begin
        idle(40);
        check(data_out, coded(16'hC35A, 1'b1, 1'b1), "old word in conversion");
        conversion_start_n = 1'b0;
        power_down_input = 1'b1;
        idle(3);
        conversion_start_n = 1'b1;
      end
    join
    check(16'(n > 99 && n < 109), 16'h0001, "no restart");
    conversion_start_n = 1'b0;
    idle(3);
    conversion_start_n = 1'b1;
    idle(8);
    check({15'h0, busy}, 16'h0000, "start in power-down");
    power_down_input = 1'b0;
    idle(4);
    check(data_out, coded(16'h5A5A, 1'b1, 1'b1), "guarded word");
    $display("guard test done");
  endtask : t_guard

  task automatic t_reset_pin();
    int n;
    int m;
    sar_data = 16'h0F0F;
    fork
      convert(200, n);
      begin
        idle(20);
        reset_pin = 1'b1;
      end
    join
    idle(6);
    check({14'h0, busy, data_oe}, 16'h0000, "abort and float");
    reset_pin = 1'b0;
    wait_busy(1'b1, 8, m);
    wait_busy(1'b0, 40, n);
    check(16'(n > 21 && n < 29), 16'h0001, "init pulse");
    idle(3);
    check({15'h0, data_oe}, 16'h0001, "bus back after init");
    check(data_out, 16'h0000, "bus cleared");
    convert(120, n);
    idle(3);
    check(data_out, coded(16'h0F0F, 1'b1, 1'b1), "continuous read");
    $display("reset pin test done");
  endtask : t_reset_pin

  task automatic t_slave_serial();
    logic [15:0] w;
    int n;
    selects(1'b1);
    serial_parallel_select = 1'b1;
    clock_source_select = 1'b1;
    output_coding_select = 1'b0;
    sar_data = 16'h9C31;
    convert(120, n);
    check(16'(n > 99 && n < 109), 16'h0001, "slave busy");
    for (int k = 0; k < 2; k++) begin
      host_u.park(k[0]);
      @(negedge core_clk);
      selects(1'b0);
      check({13'h0, sclk_oe, data_oe, serial_data_oe}, 16'h0001, "serial pins");
      host_u.read_word(w);
      check(w, coded(16'h9C31, 1'b0, 1'b0), "slave word");
      @(negedge core_clk);
      selects(1'b1);
    end
    host_u.park(1'b0);
    $display("slave serial test done");
  endtask : t_slave_serial

  task automatic t_master();
    int n;
    clock_source_select = 1'b0;
    selects(1'b0);
    for (int k = 0; k < 3; k++) begin
      invert_serial_select = (k == 1);
      read_during_convert_select = (k == 2);
      sar_data = (k == 0) ? 16'h3C96 : 16'hC369;
      idle(4);
      ms_cnt = 0;
      fv_seen = 1'b0;
      convert(300, n);
      idle(2);
      check(16'(ms_cnt), 16'h0010, "pulse count");
      check({14'h0, sclk_oe, serial_data_oe}, 16'h0003, "master pins");
      check({15'h0, fv_seen}, 16'h0001, "frame marker");
      if (k < 2) begin
        check(ms_word, coded(sar_data, 1'b0, 1'b0), "after-convert word");
        check(16'(n > 150 && n < 200), 16'h0001, "busy covers shifting");
      end else begin
        check(ms_word, coded(16'hC369, 1'b0, 1'b0), "previous word");
        check(16'(gap_last > gap_first), 16'h0001, "clock slows");
        check(16'(n < 109), 16'h0001, "busy ends with conversion");
      end
    end
    selects(1'b1);
    check({15'h0, sclk_oe}, 16'h0000, "master clock released");
    $display("master serial test done");
  endtask : t_master

  // ==========================================
  // Verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin
    idle(2);
    rst = 1'b0;
    idle(6);
    t_parallel();
    t_guard();
    t_reset_pin();
    t_slave_serial();
    t_master();
    summarize();
  end
endmodule : acr_readout_tb_top
